// ===== pkg/pcg_pkg.sv
// Constants and types shared by the PLL clock control block.
// Assumes a single 125 MHz core clock and a 16-bit register port.
`default_nettype none
package pcg_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [15:0] ADDR_FEEDBACK = 16'hF000;
	localparam logic [15:0] ADDR_PRESCALE = 16'hF001;
	localparam logic [15:0] ADDR_SOURCE   = 16'hF002;
	localparam logic [15:0] ADDR_PLL_ON   = 16'hF003;
	localparam logic [15:0] ADDR_LOCK     = 16'hF004;
	localparam logic [15:0] ADDR_RATIO    = 16'hF005;
	localparam logic [15:0] ADDR_WATCHDOG = 16'hF006;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hF010;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hF011;
	localparam logic [15:0] ADDR_G1_DEN   = 16'hF020;
	localparam logic [15:0] ADDR_G1_NUM   = 16'hF021;
	localparam logic [15:0] ADDR_G2_DEN   = 16'hF022;
	localparam logic [15:0] ADDR_G2_NUM   = 16'hF023;
	localparam logic [15:0] ADDR_G3_DEN   = 16'hF024;
	localparam logic [15:0] ADDR_G3_NUM   = 16'hF025;
	localparam logic [15:0] ADDR_G3_SRC   = 16'hF026;
	localparam logic [15:0] ADDR_G3_LOCK  = 16'hF027;
	localparam logic [15:0] ADDR_PAD      = 16'hF7A3;
	// ==========================================================
	// Values after reset
	localparam logic [15:0] FEEDBACK_RST = 16'h0060;
	localparam logic [15:0] PRESCALE_RST = 16'h0004;
	localparam logic [15:0] G1_NUM_RST   = 16'h0001;
	localparam logic [15:0] G1_DEN_RST   = 16'h0006;
	localparam logic [15:0] G2_NUM_RST   = 16'h0001;
	localparam logic [15:0] G2_DEN_RST   = 16'h0009;
	localparam logic [15:0] G3_NUM_RST   = 16'h0001;
	localparam logic [15:0] G3_DEN_RST   = 16'h0001;
	localparam logic [2:0]  PAD_RST      = 3'h1;
	// ==========================================================
	// Field positions and widths
	localparam int unsigned G12_W       = 9;
	localparam int unsigned G3_W        = 16;
	localparam int unsigned IRQ_W       = 3;
	localparam int unsigned IRQ_LOCK_UP = 0;
	localparam int unsigned IRQ_WDOG    = 1;
	localparam int unsigned IRQ_G3_LOCK = 2;
	localparam int unsigned PAD_SLEW    = 2;
	localparam logic [7:0]  GEN_DIV_LAST = 8'hFF;
	localparam int unsigned BOARD_CLOCK_OUTPUT_PIN_UNIT_SH = 3;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned PLL_LOCK_NS   = 10000;
	localparam int unsigned WDOG_NS       = 20000;
	localparam logic [15:0] PLL_LOCK_CYC =
		16'((PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] WDOG_CYC = 16'(WDOG_NS / CLK_PERIOD_NS);
	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		PLL_OFF     = 2'b00,
		PLL_LOCKING = 2'b01,
		PLL_LOCKED  = 2'b10,
		PLL_FAULT   = 2'b11
	} pcg_pll_state_t;
endpackage
`default_nettype wire

// ===== pkg/pcg_gen_if.sv
// Link between the clock control and one fractional clock generator.
// Assumes both ends run on the core clock.
`timescale 1ns/1ns
`default_nettype none
interface pcg_gen_if #(parameter int unsigned W = 9);
	logic [W-1:0] num;
	logic [W-1:0] den;
	logic         step;
	logic         restart;
	logic [4:0]   clks;
	logic         locked;
	modport gen(input num, den, step, restart, output clks, locked);
	modport ctl(output num, den, step, restart, input clks, locked);
endinterface
`default_nettype wire

// ===== core/pcg_frac_gen.sv
// One fractional audio clock generator, output = step rate * N / (1024 * M).
// Assumes step is a one-cycle enable at the system clock rate.
`timescale 1ns/1ns
`default_nettype none
module pcg_frac_gen #(
	parameter int unsigned W = 9
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	pcg_gen_if.gen    gi
);
	typedef struct packed {
		logic [7:0] div;
		logic [W:0] acc;
		logic [3:0] ph;
		logic [4:0] tick;
		logic       locked;
	} pcg_gen_state_t;

	pcg_gen_state_t q, d;
	logic [W:0]     sum;

	// Picks which of the five rates fire on a quad-rate tick.
	function automatic logic [4:0] fire_mask(input logic [3:0] ph);
		fire_mask = {ph == 4'hF, ph[2:0] == 3'h7, ph[1:0] == 2'h3, ph[0], 1'b1};
	endfunction

	// =========================================================
	// Divide by 256 first, then scale by N/M; that yields the quad rate.
	always_comb begin
		d = q;
		d.tick = 5'h00;
		sum = q.acc + {1'b0, gi.num};
		if (gi.restart) begin
			d.div = 8'h00;
			d.acc = '0;
			d.ph = 4'h0;
			d.locked = 1'b0;
		end else if (gi.step) begin
			d.div = q.div + 8'h01;
			// A zero denominator stops the generator instead of dividing by zero.
			if (q.div == pcg_pkg::GEN_DIV_LAST && gi.den != '0) begin
				if (sum >= {1'b0, gi.den}) begin
					d.acc = sum - {1'b0, gi.den};
					d.ph = q.ph + 4'h1;
					d.tick = fire_mask(q.ph);
					if (q.ph[1:0] == 2'h3) begin
						d.locked = 1'b1;
					end
				end else begin
					d.acc = sum;
				end
			end
		end
	end

	// =========================================================
	// Single state register.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Ticks are registered, so every rate is glitch free on the core clock.
	assign gi.clks = q.tick;
	assign gi.locked = q.locked;
endmodule
`default_nettype wire

// ===== core/pcg_top.sv
// PLL control, clock output and three audio clock generators.
// Assumes register strobes and all inputs are synchronous to core_clk,
// and that core_clk stands in for the PLL system clock.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Clock output ratio register selects 1x/2x/4x/8x.
// - Clock output is exact multiple of predivider.
// - Nominal ratios give 3.072 to 24.576 MHz.
// - Pad register sets output drive and slew.
// - Defaults: predivide by 4, feedback 96.
// - Generator one defaults N=1, M=6.
// - Generator two defaults N=1, M=9.
// - Generator three rate is sys/1024*N/M, or ref/1024*N/M with a reference selected.
// - Each generator has own N and M.
// - Feedback, prescale, source, enable are separate registers.
// - PLL lock readable; watchdog control provided.
// - Generator three reference select and lock bit.
// - Dejitter resync is automatic, no software control.
// - Generators one/two 9-bit, three 16-bit.
// - Each generator adds x2, x4, /2, /4.
module pcg_top (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [15:0] reg_rdata,
	input  wire logic        pll_lock_fault,
	input  wire logic [2:0]  gen_three_ref_tick,
	output var  logic        board_clock_output_pin,
	output var  logic [1:0]  clock_output_drive,
	output var  logic        clock_output_slew,
	output var  logic        pll_locked,
	output var  logic [4:0]  gen_one_clks,
	output var  logic [4:0]  gen_two_clks,
	output var  logic [4:0]  gen_three_clks,
	output var  logic        irq
);
	// =========================================================
	// State
	typedef struct packed {
		logic [15:0]                feedback;
		logic [15:0]                prescale;
		logic [15:0]                source;
		logic                       pll_on;
		logic [1:0]                 ratio;
		logic                       wdog_en;
		logic [8:0]                 g1_num;
		logic [8:0]                 g1_den;
		logic [8:0]                 g2_num;
		logic [8:0]                 g2_den;
		logic [15:0]                g3_num;
		logic [15:0]                g3_den;
		logic [1:0]                 g3_src;
		logic [2:0]                 pad;
		logic [2:0]                 stat;
		logic [2:0]                 mask;
		pcg_pkg::pcg_pll_state_t    pll_st;
		logic [15:0]                lock_cnt;
		logic [15:0]                wd_cnt;
		logic [15:0]                pre_app;
		logic [18:0]                out_cnt;
		logic                       pin;
		logic [15:0]                rdata;
		logic [2:0]                 ref_q;
		logic                       g3_lock_prev;
	} pcg_state_t;

	// Registered state and its next value.
	pcg_state_t  q, d;
	// Decodes and helpers of the combinational logic.
	logic        wr_fb;
	logic        wr_pre;
	logic        on_rise;
	logic        locked_now;
	logic [18:0] half_per;
	logic [2:0]  irq_set;
	logic [2:0]  irq_clr;
	logic        g3_step;

	pcg_gen_if #(.W(pcg_pkg::G12_W)) g1_if ();
	pcg_gen_if #(.W(pcg_pkg::G12_W)) g2_if ();
	pcg_gen_if #(.W(pcg_pkg::G3_W))  g3_if ();

	// Half period in core cycles: eight per predivider count at 1x,
	// shifted by the ratio so the pin is always an exact multiple.
	function automatic logic [18:0] half_period(input logic [15:0] pre,
		input logic [1:0] sel);
		logic [15:0] p;
		p = (pre == 16'h0000) ? 16'h0001 : pre;
		half_period = ({3'h0, p} << pcg_pkg::BOARD_CLOCK_OUTPUT_PIN_UNIT_SH) >> sel;
	endfunction

	// True when this access hits the given register.
	function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
		hit = (a == r);
	endfunction

	// =========================================================
	// Generator links
	assign locked_now = (q.pll_st == pcg_pkg::PLL_LOCKED);
	assign g1_if.num = q.g1_num;
	assign g1_if.den = q.g1_den;
	assign g2_if.num = q.g2_num;
	assign g2_if.den = q.g2_den;
	assign g3_if.num = q.g3_num;
	assign g3_if.den = q.g3_den;
	assign g1_if.step = locked_now;
	assign g2_if.step = locked_now;
	assign g3_if.step = g3_step;

	// A changed ratio restarts its generator so no mixed-rate tick escapes.
	assign g1_if.restart = !locked_now
		|| (reg_wr && (hit(reg_addr, pcg_pkg::ADDR_G1_DEN)
		|| hit(reg_addr, pcg_pkg::ADDR_G1_NUM)));

	assign g2_if.restart = !locked_now
		|| (reg_wr && (hit(reg_addr, pcg_pkg::ADDR_G2_DEN)
		|| hit(reg_addr, pcg_pkg::ADDR_G2_NUM)));

	assign g3_if.restart = !locked_now
		|| (reg_wr && (hit(reg_addr, pcg_pkg::ADDR_G3_DEN)
		|| hit(reg_addr, pcg_pkg::ADDR_G3_NUM)
		|| hit(reg_addr, pcg_pkg::ADDR_G3_SRC)));

	// Generator three runs from the system clock or a registered
	// external reference; the register stage is the resync point.
	always_comb begin
		g3_step = 1'b0;
		if (locked_now) begin
			if (q.g3_src == 2'h0) begin
				g3_step = 1'b1;
			end else begin
				// Codes one to three pick one of the reference inputs.
				g3_step = q.ref_q[q.g3_src - 2'h1];
			end
		end
	end

	// Generators one and two carry nine-bit ratios, three sixteen-bit ones.
	pcg_frac_gen #(.W(pcg_pkg::G12_W)) u_gen_one (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.gi       (g1_if.gen)
	);

	pcg_frac_gen #(.W(pcg_pkg::G12_W)) u_gen_two (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.gi       (g2_if.gen)
	);

	pcg_frac_gen #(.W(pcg_pkg::G3_W)) u_gen_three (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.gi       (g3_if.gen)
	);

	// =========================================================
	// Register writes, PLL sequencing, clock output and read data.
	always_comb begin
		d = q;
		wr_fb = reg_wr && hit(reg_addr, pcg_pkg::ADDR_FEEDBACK);
		wr_pre = reg_wr && hit(reg_addr, pcg_pkg::ADDR_PRESCALE);
		// Only an off-to-on edge of the enable latches a new predivider.
		on_rise = reg_wr && hit(reg_addr, pcg_pkg::ADDR_PLL_ON)
			&& reg_wdata[0] && !q.pll_on;
		irq_set = 3'h0;
		irq_clr = 3'h0;
		half_per = half_period(q.pre_app, q.ratio);
		d.ref_q = gen_three_ref_tick;
		d.rdata = 16'h0000;

		// Software writes.
		if (reg_wr) begin
			unique case (reg_addr)
				pcg_pkg::ADDR_FEEDBACK: d.feedback = reg_wdata;
				pcg_pkg::ADDR_PRESCALE: d.prescale = reg_wdata;
				pcg_pkg::ADDR_SOURCE:   d.source = reg_wdata;
				pcg_pkg::ADDR_PLL_ON:   d.pll_on = reg_wdata[0];
				pcg_pkg::ADDR_RATIO:    d.ratio = reg_wdata[1:0];
				pcg_pkg::ADDR_WATCHDOG: d.wdog_en = reg_wdata[0];
				pcg_pkg::ADDR_IRQ_STAT: irq_clr = reg_wdata[2:0];
				pcg_pkg::ADDR_IRQ_MASK: d.mask = reg_wdata[2:0];
				pcg_pkg::ADDR_G1_DEN:   d.g1_den = reg_wdata[8:0];
				pcg_pkg::ADDR_G1_NUM:   d.g1_num = reg_wdata[8:0];
				pcg_pkg::ADDR_G2_DEN:   d.g2_den = reg_wdata[8:0];
				pcg_pkg::ADDR_G2_NUM:   d.g2_num = reg_wdata[8:0];
				pcg_pkg::ADDR_G3_DEN:   d.g3_den = reg_wdata;
				pcg_pkg::ADDR_G3_NUM:   d.g3_num = reg_wdata;
				pcg_pkg::ADDR_G3_SRC:   d.g3_src = reg_wdata[1:0];
				pcg_pkg::ADDR_PAD:      d.pad = reg_wdata[2:0];
				default: ;
			endcase
		end

		// PLL sequencing.
		unique case (q.pll_st)
			pcg_pkg::PLL_OFF: begin
				if (on_rise) begin
					// The new predivider only reaches the pin on re-enable.
					d.pre_app = q.prescale;
					d.pll_st = pcg_pkg::PLL_LOCKING;
					d.lock_cnt = 16'h0000;
					d.wd_cnt = 16'h0000;
				end
			end
			pcg_pkg::PLL_LOCKING: begin
				d.lock_cnt = q.lock_cnt + 16'h0001;
				d.wd_cnt = q.wd_cnt + 16'h0001;
				// A faulty loop never settles, so the count holds at zero.
				if (pll_lock_fault) begin
					d.lock_cnt = 16'h0000;
				end else if (q.lock_cnt == pcg_pkg::PLL_LOCK_CYC - 16'h0001) begin
					d.pll_st = pcg_pkg::PLL_LOCKED;
					irq_set[pcg_pkg::IRQ_LOCK_UP] = 1'b1;
				end

				// The watchdog kicks a stuck lock attempt and flags it.
				if (q.wdog_en && q.wd_cnt == pcg_pkg::WDOG_CYC - 16'h0001) begin
					d.lock_cnt = 16'h0000;
					d.wd_cnt = 16'h0000;
					irq_set[pcg_pkg::IRQ_WDOG] = 1'b1;
				end
			end
			pcg_pkg::PLL_LOCKED: begin
				if (pll_lock_fault) begin
					// Without the watchdog a lost lock waits for software.
					d.pll_st = q.wdog_en ? pcg_pkg::PLL_LOCKING : pcg_pkg::PLL_FAULT;
					d.lock_cnt = 16'h0000;
					d.wd_cnt = 16'h0000;
					irq_set[pcg_pkg::IRQ_WDOG] = 1'b1;
				end
			end
			pcg_pkg::PLL_FAULT: begin
				// Held until software clears the enable or writes a divider; nothing retries here.
			end
		endcase

		// Divider changes while running drop lock until it settles again.
		if ((wr_fb || wr_pre) && q.pll_st != pcg_pkg::PLL_OFF) begin
			d.pll_st = pcg_pkg::PLL_LOCKING;
			d.lock_cnt = 16'h0000;
			d.wd_cnt = 16'h0000;
		end

		// Turning the PLL off wins over every other transition.
		if (!d.pll_on) begin
			d.pll_st = pcg_pkg::PLL_OFF;
		end

		// Clock output, driven low from the cycle after the PLL leaves lock.
		// The counter restarts on each toggle, so a new ratio lands within a half period.
		if (locked_now) begin
			if (q.out_cnt >= half_per - 19'h00001) begin
				d.out_cnt = 19'h00000;
				d.pin = !q.pin;
			end else begin
				d.out_cnt = q.out_cnt + 19'h00001;
			end
		end else begin
			d.out_cnt = 19'h00000;
			d.pin = 1'b0;
		end

		// Generator three lock event on its rising edge.
		d.g3_lock_prev = g3_if.locked;
		if (g3_if.locked && !q.g3_lock_prev) begin
			irq_set[pcg_pkg::IRQ_G3_LOCK] = 1'b1;
		end

		// A new event in the clearing cycle survives.
		d.stat = (q.stat & ~irq_clr) | irq_set;

		// Read data stands only in the cycle after the strobe.
		if (reg_rd) begin
			unique case (reg_addr)
				pcg_pkg::ADDR_FEEDBACK: d.rdata = q.feedback;
				pcg_pkg::ADDR_PRESCALE: d.rdata = q.prescale;
				pcg_pkg::ADDR_SOURCE:   d.rdata = q.source;
				pcg_pkg::ADDR_PLL_ON:   d.rdata = {15'h0000, q.pll_on};
				pcg_pkg::ADDR_LOCK:     d.rdata = {15'h0000, locked_now};
				pcg_pkg::ADDR_RATIO:    d.rdata = {14'h0000, q.ratio};
				pcg_pkg::ADDR_WATCHDOG: d.rdata = {15'h0000, q.wdog_en};
				pcg_pkg::ADDR_IRQ_STAT: d.rdata = {13'h0000, q.stat};
				pcg_pkg::ADDR_IRQ_MASK: d.rdata = {13'h0000, q.mask};
				pcg_pkg::ADDR_G1_DEN:   d.rdata = {7'h00, q.g1_den};
				pcg_pkg::ADDR_G1_NUM:   d.rdata = {7'h00, q.g1_num};
				pcg_pkg::ADDR_G2_DEN:   d.rdata = {7'h00, q.g2_den};
				pcg_pkg::ADDR_G2_NUM:   d.rdata = {7'h00, q.g2_num};
				pcg_pkg::ADDR_G3_DEN:   d.rdata = q.g3_den;
				pcg_pkg::ADDR_G3_NUM:   d.rdata = q.g3_num;
				pcg_pkg::ADDR_G3_SRC:   d.rdata = {14'h0000, q.g3_src};
				pcg_pkg::ADDR_G3_LOCK:  d.rdata = {15'h0000, g3_if.locked};
				pcg_pkg::ADDR_PAD:      d.rdata = {13'h0000, q.pad};
				default:                d.rdata = 16'h0000;
			endcase
		end
	end

	// =========================================================
	// State register with documented defaults.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Fields not named below clear to zero.
			q <= '0;
			q.feedback <= pcg_pkg::FEEDBACK_RST;
			q.prescale <= pcg_pkg::PRESCALE_RST;
			q.pre_app <= pcg_pkg::PRESCALE_RST;
			q.wdog_en <= 1'b1;
			q.g1_num <= pcg_pkg::G1_NUM_RST[8:0];
			q.g1_den <= pcg_pkg::G1_DEN_RST[8:0];
			q.g2_num <= pcg_pkg::G2_NUM_RST[8:0];
			q.g2_den <= pcg_pkg::G2_DEN_RST[8:0];
			q.g3_num <= pcg_pkg::G3_NUM_RST;
			q.g3_den <= pcg_pkg::G3_DEN_RST;
			q.pad <= pcg_pkg::PAD_RST;
			q.pll_st <= pcg_pkg::PLL_OFF;
		end else begin
			q <= d;
		end
	end

	// =========================================================
	// Outputs, all from flip-flops except the interrupt level and the lock flag decode.
	assign reg_rdata = q.rdata;
	assign board_clock_output_pin = q.pin;
	// Pad controls follow the register one cycle after a write.
	assign clock_output_drive = q.pad[1:0];
	assign clock_output_slew = q.pad[pcg_pkg::PAD_SLEW];
	assign pll_locked = locked_now;
	assign gen_one_clks = g1_if.clks;
	assign gen_two_clks = g2_if.clks;
	assign gen_three_clks = g3_if.clks;
	// The interrupt is a level, high while any unmasked status bit is set.
	assign irq = |(q.stat & q.mask);
endmodule
`default_nettype wire

// ===== test/pcg_top_asserts.sv
// Checker for the PLL clock control block, bound to its top module.
// Assumes it sees only the top ports and shares the core clock.
`timescale 1ns/1ns
`default_nettype none
module pcg_top_asserts (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        pll_lock_fault,
	input wire logic [2:0]  gen_three_ref_tick,
	input wire logic        board_clock_output_pin,
	input wire logic [1:0]  clock_output_drive,
	input wire logic        clock_output_slew,
	input wire logic        pll_locked,
	input wire logic [4:0]  gen_one_clks,
	input wire logic [4:0]  gen_two_clks,
	input wire logic [4:0]  gen_three_clks,
	input wire logic        irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// Helper logic
	logic        en_q;
	logic [15:0] ucnt_q;
	logic        start;
	// A lock attempt starts on an enable edge, a divider write or a fault.
	assign start = (reg_wr && ((reg_addr == 16'hF003 && reg_wdata[0] && !en_q)
		|| reg_addr == 16'hF000 || reg_addr == 16'hF001)) || pll_lock_fault;
	// Count unlocked cycles since the last start; saturates so it never wraps.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_q <= 1'b0;
			ucnt_q <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == 16'hF003)
				en_q <= reg_wdata[0];
			if (start)
				ucnt_q <= 16'h0000;
			else if (!pll_locked && ucnt_q != 16'hFFFF)
				ucnt_q <= ucnt_q + 16'h0001;
		end
	end
	// ==========================================
	// Assertions
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	AST_PIN_LOW: assert property (!pll_locked && !$past(pll_locked) |-> !board_clock_output_pin)
		else $error("clock pin active while unlocked");
	AST_LOCK_MIN: assert property ($rose(pll_locked) |-> ucnt_q >= 16'h04E0)
		else $error("lock reported too early");
	AST_PAD: assert property (reg_wr && reg_addr == 16'hF7A3 |=>
		{clock_output_slew, clock_output_drive} == $past(reg_wdata[2:0]))
		else $error("pad drive or slew not taken");
	AST_PULSE_ONE: assert property (gen_one_clks[0] |=> !gen_one_clks[0])
		else $error("generator pulse longer than one cycle");
	AST_MASK_OFF: assert property (reg_wr && reg_addr == 16'hF011 && reg_wdata == 16'h0000 |=> ##1 !irq)
		else $error("interrupt high with all masked");
	AST_DISABLE: assert property (reg_wr && reg_addr == 16'hF003 && !reg_wdata[0] |-> ##2 !pll_locked [*4])
		else $error("lock held after disable");
	AST_DIV_WRITE: assert property (reg_wr && (reg_addr == 16'hF000 || reg_addr == 16'hF001)
		|-> ##2 !pll_locked [*4])
		else $error("lock held over divider change");
	AST_G1_WIDTH: assert property (reg_rd && reg_addr == 16'hF020 |=> reg_rdata[15:9] == 7'h00)
		else $error("generator one field wider than nine bits");
	AST_SUB_RATES: assert property (gen_one_clks[4:2] != 3'h0 |-> gen_one_clks[1:0] == 2'h3)
		else $error("slower generator rate without the faster ones");
	// ==========================================
	// Coverage of the main scenarios
	COV_LOCK: cover property ($rose(pll_locked));
	COV_IRQ: cover property ($rose(irq));
	COV_G3: cover property (gen_three_clks[0]);
	COV_PAD: cover property (reg_wr && reg_addr == 16'hF7A3);
endmodule
bind pcg_top pcg_top_asserts chk_u (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .pll_lock_fault, .gen_three_ref_tick, .board_clock_output_pin,
	.clock_output_drive, .clock_output_slew, .pll_locked, .gen_one_clks, .gen_two_clks,
	.gen_three_clks, .irq);
`default_nettype wire

// ===== test/pcg_codec_model.sv
// Board codec model that measures the clock it is fed.
// Assumes the clock pin is sampled on the core clock.
`timescale 1ns/1ns
`default_nettype none
module pcg_codec_model (
	input  wire logic        core_clk,
	input  wire logic        mclk,
	output var  logic [15:0] period
);
	logic [15:0] cnt = 16'h0000;
	logic        last = 1'b0;
	logic [15:0] per_q = 16'h0000;
	// A codec only sees rising edges, so their spacing is what it locks to.
	assign period = per_q;
	always @(posedge core_clk) begin
		cnt <= cnt + 16'h0001;
		last <= mclk;
		if (mclk && !last) begin
			per_q <= cnt + 16'h0001;
			cnt <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ===== test/pcg_top_test.sv
// Self-checking bench for the PLL clock control block.
// Assumes the checker is bound to the top and the codec model sits on the pin.
`timescale 1ns/1ns
`default_nettype none
module pcg_top_test;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        pll_lock_fault = 1'b0;
	logic [2:0]  gen_three_ref_tick = 3'h0;
	logic [15:0] reg_rdata, period, v;
	logic        board_clock_output_pin, clock_output_slew, pll_locked, irq;
	logic [1:0]  clock_output_drive;
	logic [4:0]  gen_one_clks, gen_two_clks, gen_three_clks;
	logic [16:0] lfsr = 17'h1366E;
	logic        rd_d = 1'b0;
	logic [15:0] expq[$];
	int          fail_count = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [15:0] ra[14] = '{16'hF000, 16'hF001, 16'hF003, 16'hF004, 16'hF005, 16'hF020,
		16'hF021, 16'hF022, 16'hF023, 16'hF024, 16'hF025, 16'hF7A3, 16'hF011, 16'hF0FF};
	logic [15:0] re[14] = '{16'h0060, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0006,
		16'h0001, 16'h0009, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
	pcg_top dut_u (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pll_lock_fault, .gen_three_ref_tick, .board_clock_output_pin, .clock_output_drive,
		.clock_output_slew, .pll_locked, .gen_one_clks, .gen_two_clks, .gen_three_clks, .irq);
	pcg_codec_model codec_u (.core_clk, .mclk(board_clock_output_pin), .period);
	// ==========================================
	// Clock, random reference ticks and timeout
	initial forever #4 core_clk = ~core_clk;
	// Ticks skip a cycle after each event on bit 0 so its pulses never run together.
	always @(posedge core_clk) begin
		lfsr <= lfsr_next(lfsr);
		gen_three_ref_tick <= gen_three_ref_tick[0] ? 3'h0 : lfsr[2:0];
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			summarize();
		end
	end
	// Read data stands only in the cycle after the strobe.
	always @(posedge core_clk) begin
		if (rd_d)
			chk("reg_rdata", expq.pop_front(), reg_rdata);
		rd_d <= reg_rd;
	end
	// ==========================================
	// Tasks
	// Seventeen-bit maximal-length shift register step.
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		expq.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic wait_lock();
		int n;
		n = 0;
		repeat (4) @(posedge core_clk);
		while (pll_locked !== 1'b1 && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		chk("pll_locked", 16'h0001, 16'(pll_locked));
	endtask
	function automatic logic x4(input int g);
		return g == 1 ? gen_one_clks[0] : g == 2 ? gen_two_clks[0] : gen_three_clks[0];
	endfunction
	// Spacing between two fastest pulses of one generator.
	task automatic gap(input int g, input logic [15:0] e);
		int n;
		n = 0;
		while (x4(g) !== 1'b1 && n < 5000) begin
			@(posedge core_clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (x4(g) !== 1'b1 && n < 5000);
		chk("x4 gap", e, 16'(n));
	endtask
	task automatic summarize();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 14; i++)
			rd(ra[i], re[i]);
		wr(16'hF7A3, 16'h0006);
		@(posedge core_clk);
		chk("pad", 16'h0006, {13'h0000, clock_output_slew, clock_output_drive});
		wr(16'hF011, 16'h0000);
		wr(16'hF003, 16'h0001);
		wait_lock();
		chk("irq masked", 16'h0000, 16'(irq));
		wr(16'hF011, 16'h0001);
		repeat (2) @(posedge core_clk);
		chk("irq", 16'h0001, 16'(irq));
		rd(16'hF010, 16'h0001);
		wr(16'hF010, 16'h0001);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", 16'h0000, 16'(irq));
		gap(1, 16'd1536);
		gap(2, 16'd2304);
		gap(3, 16'd256);
		for (int r = 3; r >= 0; r--) begin
			wr(16'hF005, 16'(r));
			repeat (200) @(posedge core_clk);
			chk("period", 16'h0040 >> r, period);
		end
		pll_lock_fault <= 1'b1;
		@(posedge core_clk);
		pll_lock_fault <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("pll_locked", 16'h0000, 16'(pll_locked));
		rd(16'hF010, 16'h0006);
		wait_lock();
		wr(16'hF010, 16'h0003);
		wr(16'hF001, 16'h0002);
		wait_lock();
		repeat (200) @(posedge core_clk);
		chk("period", 16'h0040, period);
		wr(16'hF003, 16'h0000);
		rd(16'hF004, 16'h0000);
		wr(16'hF003, 16'h0001);
		wait_lock();
		repeat (200) @(posedge core_clk);
		chk("period", 16'h0020, period);
		v = lfsr[15:0];
		wr(16'hF021, v);
		wr(16'hF025, ~v);
		wr(16'hF020, 16'hFFFF);
		rd(16'hF021, {7'h00, v[8:0]});
		rd(16'hF025, ~v);
		rd(16'hF020, 16'h01FF);
		wr(16'hF025, 16'h0001);
		wr(16'hF026, 16'h0001);
		rd(16'hF026, 16'h0001);
		rd(16'hF027, 16'h0000);
		repeat (6000) @(posedge core_clk);
		rd(16'hF027, 16'h0001);
		wr(16'hF026, 16'h0003);
		rd(16'hF027, 16'h0000);
		repeat (6000) @(posedge core_clk);
		rd(16'hF027, 16'h0001);
		wr(16'hF002, v);
		wr(16'hF006, 16'h0000);
		rd(16'hF002, v);
		rd(16'hF006, 16'h0000);
		repeat (2) @(posedge core_clk);
		summarize();
	end
endmodule
`default_nettype wire
